/* include/shutdown_pkg.sv */
package shutdown_pkg;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLOCK_HZ = 10_000_000;
    localparam int SYNC_PULSE_NS = 500;
    localparam int SYNC_PULSE_CYCLES = (SYNC_PULSE_NS * (CLOCK_HZ / 1_000_000) + 999) / 1000;
    localparam int VOFF_SETTLE_MIN_MS = 90;
    localparam int VOFF_SETTLE_CYCLES = VOFF_SETTLE_MIN_MS * (CLOCK_HZ / 1000);
    localparam int RESTART_EXTRA_MS = 136;
    localparam int RESTART_EXTRA_CYCLES = RESTART_EXTRA_MS * (CLOCK_HZ / 1000);
    localparam int SYNC_LOSS_CYCLES = 64;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int CHCFG_NO_DECAY_WAIT = 0;
    localparam int CHCFG_SHARE_CLK_REQ = 2;
    localparam int GCFG_EXT_CLK_REQ = 4;
    localparam int PAD_SYNC_DRIVER = 10;
    localparam int COMP_RES_LSB = 0;
    localparam int COMP_GM_LSB = 5;
    localparam int GAIN_LSB = 5;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] COMP_RESET = 8'h00;
    localparam logic [7:0] PWM_CONFIG_RESET = 8'h00;

    typedef enum logic [2:0] {
        ST_OFF = 3'b000,
        ST_RAMP_UP = 3'b001,
        ST_ACTIVE = 3'b010,
        ST_OFF_WAIT = 3'b011,
        ST_FALL = 3'b100,
        ST_DISCHARGE = 3'b101,
        ST_RETRY = 3'b110,
        ST_LATCHED = 3'b111
    } chan_state_e;

endpackage

/* include/sync_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface sync_if;
    logic syncIn;
    logic masterEnable;
    logic periodPulse;
    logic syncOe_n;
    logic syncDriving;
    logic extClockPresent;
    modport engine (input syncIn, input masterEnable, input periodPulse,
        output syncOe_n, output syncDriving, output extClockPresent);
    modport user (output syncIn, output masterEnable, output periodPulse,
        input syncOe_n, input syncDriving, input extClockPresent);
endinterface
`default_nettype wire

/* src/sync_master.sv */
`timescale 1ns/1ps
`default_nettype none
module sync_master (
    input wire logic clock,
    input wire logic rst_n,
    sync_if.engine sif
);
    typedef struct packed {
        logic [7:0] pulseCnt;
        logic [7:0] quietCnt;
        logic lost;
        logic syncPrev;
    } sync_state_s;

    sync_state_s state_reg;
    sync_state_s state_next;

    // ----------------------------------------------------------------
    // Drive, arbitration and presence detection
    // ----------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        state_next.syncPrev = sif.syncIn;
        if (state_reg.pulseCnt != 8'h00) begin
            state_next.pulseCnt = state_reg.pulseCnt - 8'h01;
        end else if (sif.periodPulse && sif.masterEnable && !state_reg.lost) begin
            state_next.pulseCnt = 8'(shutdown_pkg::SYNC_PULSE_CYCLES);
        end
        // Foreign fall while quiet: another master won
        if (state_reg.syncPrev && !sif.syncIn && state_reg.pulseCnt == 8'h00) begin
            state_next.quietCnt = 8'h00;
            state_next.lost = 1'b1;
        end else if (state_reg.quietCnt != 8'(shutdown_pkg::SYNC_LOSS_CYCLES)) begin
            state_next.quietCnt = state_reg.quietCnt + 8'h01;
        end else begin
            state_next.lost = 1'b0;
        end
        if (!sif.masterEnable) begin
            state_next.pulseCnt = 8'h00;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    // Low enable pulls the open-drain line low
    assign sif.syncOe_n = (state_reg.pulseCnt == 8'h00);
    assign sif.syncDriving = sif.masterEnable && !state_reg.lost;
    assign sif.extClockPresent = state_reg.quietCnt != 8'(shutdown_pkg::SYNC_LOSS_CYCLES) && state_reg.lost;
endmodule // sync_master
`default_nettype wire

/* src/channel_shutdown_retry_sync_control.sv */
// Behaviour
// - Continuous shutdown waits turn-off delay, then ramps down sinking current.
// - Discontinuous shutdown never sinks load current.
// - Fault, lost shared clock, low input or inhibit fault pin stop switching at once.
// - Run low or off command move ramp-up or active into shutdown; fault goes to retry or latch-off.
// - Discharge variant switches until below off threshold, then stops 90-300 ms later.
// - Retry mode holds channel off for retry wait, then restarts.
// - Base variant retry waits longer of delay or decay below 12.5 percent.
// - Discharge variant, bit 0 clear: wait for decay too; warn if decay too long.
// - Bit 0 set: retry wait alone, restart into pre-bias, no warning.
// - Shared fault pin: each channel's own output decay sets its retry wait.
// - Latch-off holds channel off until run toggles or off/on command.
// - Start in discontinuous mode, then run in commanded mode.
// - Input overvoltage reading turns the channel off.
// - Compensation low five bits pick resistor, upper three the transconductance.
// - Two-bit field picks input sense gain 2x, 4x or 8x.
// - As master, pull sync low 500 ns each switching period.
// - Among competing masters one keeps driving, others drop out.
// - Flag external sync when present; internal period counter always runs, never locked to it.
// - Global bit 4 set forbids starting to switch without an external clock.
// - Pad status bit 10 shows the sync driver state.
// - Channel phase sets delay from the internal period counter wrap to top switch on.
// - Frequency and phase writes accepted only while both channels are off.
// - Run held low for at least turn-off delay plus fall plus 136 ms.
`timescale 1ns/1ps
`default_nettype none
module channel_shutdown_retry_sync_control #(
    parameter int CHANNELS = 2,
    parameter bit DISCHARGE_VARIANT = 1'b0,
    parameter int VOFF_SETTLE = shutdown_pkg::VOFF_SETTLE_CYCLES,
    parameter int RESTART_EXTRA = shutdown_pkg::RESTART_EXTRA_CYCLES
) (
    input wire logic clock,
    input wire logic rst_n,
    // Per-channel control, same clock domain
    input wire logic [CHANNELS-1:0] opOn,
    input wire logic [CHANNELS-1:0] faultDetected,
    input wire logic [CHANNELS-1:0] faultPinLow,
    input wire logic [CHANNELS-1:0] inhibitResponse,
    input wire logic [CHANNELS-1:0] latchOff,
    input wire logic [CHANNELS-1:0] vinOverLimit,
    input wire logic vinBelowOff,
    input wire logic [CHANNELS-1:0] belowEighth,
    input wire logic [CHANNELS-1:0] belowVoffThreshold,
    input wire logic [CHANNELS-1:0] rampDone,
    input wire logic [CHANNELS-1:0] forcedContinuous,
    input wire logic [7:0] channelConfig [CHANNELS],
    input wire logic [7:0] globalConfig,
    input wire logic [23:0] turnOffWait [CHANNELS],
    input wire logic [23:0] rampDownTime [CHANNELS],
    input wire logic [31:0] retryWait [CHANNELS],
    input wire logic [31:0] restartHold [CHANNELS],
    input wire logic [31:0] turnOffMaxWarnLimit [CHANNELS],
    // Pins
    input wire logic [CHANNELS-1:0] runIn,
    output logic [CHANNELS-1:0] runOut,
    output logic [CHANNELS-1:0] runOe_n,
    input wire logic shareClkIn,
    input wire logic syncIn,
    output logic syncOut,
    output logic syncOe_n,
    // Switching clock configuration
    input wire logic syncMasterCfg,
    input wire logic [15:0] periodCycles,
    input wire logic [15:0] phaseCycles [CHANNELS],
    input wire logic cfgWrite,
    input wire logic [7:0] pwmConfigIn,
    input wire logic [7:0] compWrite,
    input wire logic compWriteEn,
    // Outputs to the power stage
    output logic [CHANNELS-1:0] switching,
    output logic [CHANNELS-1:0] sinkEnable,
    output logic [CHANNELS-1:0] continuousMode,
    output logic [CHANNELS-1:0] topSwitchSet,
    output logic [CHANNELS-1:0] turnOffMaxWarn,
    output logic [4:0] compResistor,
    output logic [2:0] errorAmpGm,
    output logic [1:0] inputSenseGain,
    output logic [7:0] loop_compensation_setting,
    output logic [7:0] pwmPhaseConfig,
    output logic [15:0] padStatusWord,
    output logic cfgRefused
);
    typedef struct packed {
        shutdown_pkg::chan_state_e st;
        logic [31:0] timer;
        logic [31:0] decayCnt;
        logic [31:0] holdCnt;
        logic waitDone;
        logic decayDone;
        logic runPrev;
        logic latchedRunSeen;
        logic warn;
        logic mode;
    } chan_s;

    typedef struct packed {
        chan_s [CHANNELS-1:0] ch;
        logic [15:0] periodCnt;
        logic [7:0] comp;
        logic [7:0] pwmCfg;
        logic refused;
        logic [1:0] shareSync;
        logic [1:0] syncSync;
        logic [CHANNELS*2-1:0] runSync;
        logic [7:0] shareQuiet;
        logic sharePrev;
    } state_s;

    state_s state_reg;
    state_s state_next;

    sync_if sif ();

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] restartMin(input logic [23:0] toff, input logic [23:0] fall,
        input logic [31:0] cmd, input int extra);
        logic [31:0] floorVal;
        floorVal = 32'(toff) + 32'(fall) + 32'(extra);
        restartMin = (cmd > floorVal) ? cmd : floorVal;
    endfunction

    function automatic logic inOff(input shutdown_pkg::chan_state_e s);
        inOff = (s == shutdown_pkg::ST_OFF) || (s == shutdown_pkg::ST_RETRY) || (s == shutdown_pkg::ST_LATCHED);
    endfunction

    logic shareClkLost;
    logic allOff;

    assign shareClkLost = (state_reg.shareQuiet == 8'(shutdown_pkg::SYNC_LOSS_CYCLES));

    always_comb begin
        allOff = 1'b1;
        for (int i = 0; i < CHANNELS; i++) begin
            if (!inOff(state_reg.ch[i].st)) begin
                allOff = 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        logic runLvl;
        logic hardStop;
        logic softStop;
        logic enable;
        logic noWait;
        logic decayOk;
        state_next = state_reg;
        runLvl = 1'b0;
        hardStop = 1'b0;
        softStop = 1'b0;
        enable = 1'b0;
        noWait = 1'b0;
        decayOk = 1'b0;
        // Pins pass two flops before use
        state_next.shareSync = {state_reg.shareSync[0], shareClkIn};
        state_next.syncSync = {state_reg.syncSync[0], syncIn};
        for (int i = 0; i < CHANNELS; i++) begin
            state_next.runSync[2*i+1] = state_reg.runSync[2*i];
            state_next.runSync[2*i] = runIn[i];
        end
        state_next.sharePrev = state_reg.shareSync[1];
        if (state_reg.sharePrev != state_reg.shareSync[1]) begin
            state_next.shareQuiet = 8'h00;
        end else if (!shareClkLost) begin
            state_next.shareQuiet = state_reg.shareQuiet + 8'h01;
        end
        // Switching period counter
        if (state_reg.periodCnt >= periodCycles - 16'h0001) begin
            state_next.periodCnt = 16'h0000;
        end else begin
            state_next.periodCnt = state_reg.periodCnt + 16'h0001;
        end
        if (compWriteEn) begin
            state_next.comp = compWrite;
        end
        state_next.refused = 1'b0;
        if (cfgWrite) begin
            if (allOff) begin
                state_next.pwmCfg = pwmConfigIn;
            end else begin
                state_next.refused = 1'b1;
            end
        end

        for (int i = 0; i < CHANNELS; i++) begin
            runLvl = state_reg.runSync[2*i+1];
            noWait = channelConfig[i][shutdown_pkg::CHCFG_NO_DECAY_WAIT];
            // Fault pin stops the channel only with its inhibit response set; no decay is shared
            hardStop = faultDetected[i] || vinOverLimit[i] || vinBelowOff
                || (shareClkLost && channelConfig[i][shutdown_pkg::CHCFG_SHARE_CLK_REQ])
                || (faultPinLow[i] && inhibitResponse[i]);
            softStop = !runLvl || !opOn[i];
            enable = runLvl && opOn[i] && state_reg.ch[i].holdCnt == 32'h0
                && (!globalConfig[shutdown_pkg::GCFG_EXT_CLK_REQ] || sif.extClockPresent);
            decayOk = DISCHARGE_VARIANT ? (noWait || belowVoffThreshold[i]) : belowEighth[i];
            state_next.ch[i].runPrev = runLvl;
            if (state_reg.ch[i].holdCnt != 32'h0) begin
                state_next.ch[i].holdCnt = state_reg.ch[i].holdCnt - 32'h1;
            end
            if (state_reg.ch[i].runPrev && !runLvl) begin
                state_next.ch[i].holdCnt = restartMin(turnOffWait[i], rampDownTime[i],
                    restartHold[i], RESTART_EXTRA);
            end
            if (state_reg.ch[i].timer != 32'h0) begin
                state_next.ch[i].timer = state_reg.ch[i].timer - 32'h1;
            end
            case (state_reg.ch[i].st)
                shutdown_pkg::ST_OFF: begin
                    state_next.ch[i].mode = 1'b0;
                    if (enable) begin
                        state_next.ch[i].st = shutdown_pkg::ST_RAMP_UP;
                    end
                end
                shutdown_pkg::ST_RAMP_UP, shutdown_pkg::ST_ACTIVE: begin
                    if (state_reg.ch[i].st == shutdown_pkg::ST_RAMP_UP && rampDone[i]) begin
                        state_next.ch[i].st = shutdown_pkg::ST_ACTIVE;
                        state_next.ch[i].mode = forcedContinuous[i];
                    end
                    if (softStop) begin
                        state_next.ch[i].timer = 32'(turnOffWait[i]);
                        state_next.ch[i].st = shutdown_pkg::ST_OFF_WAIT;
                    end
                end
                shutdown_pkg::ST_OFF_WAIT: begin
                    if (state_reg.ch[i].timer == 32'h0) begin
                        state_next.ch[i].timer = 32'(rampDownTime[i]);
                        state_next.ch[i].st = shutdown_pkg::ST_FALL;
                    end
                end
                shutdown_pkg::ST_FALL: begin
                    if (state_reg.ch[i].timer == 32'h0) begin
                        if (DISCHARGE_VARIANT) begin
                            state_next.ch[i].st = shutdown_pkg::ST_DISCHARGE;
                        end else begin
                            state_next.ch[i].st = shutdown_pkg::ST_OFF;
                        end
                    end
                end
                shutdown_pkg::ST_DISCHARGE: begin
                    // Settling starts once output reads low
                    if (!belowVoffThreshold[i]) begin
                        state_next.ch[i].timer = 32'(VOFF_SETTLE);
                    end else if (state_reg.ch[i].timer == 32'h0) begin
                        state_next.ch[i].st = shutdown_pkg::ST_OFF;
                    end
                end
                shutdown_pkg::ST_RETRY: begin
                    if (state_reg.ch[i].timer == 32'h0) begin
                        state_next.ch[i].waitDone = 1'b1;
                    end
                    if (decayOk) begin
                        state_next.ch[i].decayDone = 1'b1;
                    end else begin
                        state_next.ch[i].decayCnt = state_reg.ch[i].decayCnt + 32'h1;
                    end
                    if (DISCHARGE_VARIANT && !noWait && !decayOk
                            && state_reg.ch[i].decayCnt >= turnOffMaxWarnLimit[i]) begin
                        state_next.ch[i].warn = 1'b1;
                    end
                    if (state_reg.ch[i].waitDone && state_reg.ch[i].decayDone) begin
                        state_next.ch[i].waitDone = 1'b0;
                        state_next.ch[i].decayDone = 1'b0;
                        state_next.ch[i].st = shutdown_pkg::ST_OFF;
                    end
                end
                shutdown_pkg::ST_LATCHED: begin
                    if (softStop) begin
                        state_next.ch[i].latchedRunSeen = 1'b1;
                    end else if (state_reg.ch[i].latchedRunSeen) begin
                        state_next.ch[i].latchedRunSeen = 1'b0;
                        state_next.ch[i].st = shutdown_pkg::ST_OFF;
                    end
                end
                default: begin
                    state_next.ch[i].st = shutdown_pkg::ST_OFF;
                end
            endcase
            // Faults stop any switching state
            if (hardStop && !inOff(state_reg.ch[i].st)) begin
                state_next.ch[i].decayCnt = 32'h0;
                state_next.ch[i].timer = retryWait[i];
                state_next.ch[i].st = latchOff[i] ? shutdown_pkg::ST_LATCHED
                    : shutdown_pkg::ST_RETRY;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= '0;
            state_reg.comp <= shutdown_pkg::COMP_RESET;
            state_reg.pwmCfg <= shutdown_pkg::PWM_CONFIG_RESET;
            state_reg.shareSync <= 2'b11;
            state_reg.syncSync <= 2'b11;
        end else begin
            state_reg <= state_next;
        end
    end

    // ----------------------------------------------------------------
    // Sync line engine
    // ----------------------------------------------------------------
    assign sif.syncIn = state_reg.syncSync[1];
    assign sif.masterEnable = syncMasterCfg;
    assign sif.periodPulse = (state_reg.periodCnt == 16'h0000);

    sync_master u_sync (
        .clock(clock),
        .rst_n(rst_n),
        .sif(sif.engine)
    );

    assign syncOut = 1'b0;
    assign syncOe_n = sif.syncOe_n;

    // ----------------------------------------------------------------
    // Channel outputs
    // ----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < CHANNELS; g++) begin : gen_out
            assign switching[g] = !inOff(state_reg.ch[g].st);
            assign sinkEnable[g] = state_reg.ch[g].mode
                && (state_reg.ch[g].st == shutdown_pkg::ST_FALL
                || state_reg.ch[g].st == shutdown_pkg::ST_DISCHARGE);
            assign continuousMode[g] = state_reg.ch[g].mode;
            // Top switch turns on at the phase offset
            assign topSwitchSet[g] = switching[g] && (state_reg.periodCnt == phaseCycles[g]);
            assign turnOffMaxWarn[g] = state_reg.ch[g].warn;
            assign runOut[g] = 1'b0;
            assign runOe_n[g] = (state_reg.ch[g].holdCnt == 32'h0);
        end
    endgenerate

    assign compResistor = state_reg.comp[shutdown_pkg::COMP_RES_LSB +: 5];
    assign errorAmpGm = state_reg.comp[shutdown_pkg::COMP_GM_LSB +: 3];
    assign inputSenseGain = state_reg.pwmCfg[shutdown_pkg::GAIN_LSB +: 2];
    assign loop_compensation_setting = state_reg.comp;
    assign pwmPhaseConfig = state_reg.pwmCfg;
    assign cfgRefused = state_reg.refused;

    always_comb begin
        padStatusWord = 16'h0000;
        padStatusWord[shutdown_pkg::PAD_SYNC_DRIVER] = sif.syncDriving;
    end
endmodule // channel_shutdown_retry_sync_control
`default_nettype wire

/* tb/channel_shutdown_retry_sync_control_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module channel_shutdown_retry_sync_control_assertions #(
    parameter int CHANNELS = 2,
    parameter int RESTART_EXTRA = 20
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [CHANNELS-1:0] faultDetected,
    input wire logic vinBelowOff,
    input wire logic cfgWrite,
    input wire logic compWriteEn,
    input wire logic [7:0] compWrite,
    input wire logic [CHANNELS-1:0] switching,
    input wire logic [CHANNELS-1:0] sinkEnable,
    input wire logic [CHANNELS-1:0] continuousMode,
    input wire logic [CHANNELS-1:0] runOe_n,
    input wire logic syncOe_n,
    input wire logic cfgRefused,
    input wire logic [4:0] compResistor,
    input wire logic [2:0] errorAmpGm,
    input wire logic [7:0] loop_compensation_setting,
    input wire logic [7:0] pwmPhaseConfig,
    input wire logic [15:0] padStatusWord
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    int lowCnt;
    // Length of the current run hold
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            lowCnt <= 0;
        end else begin
            lowCnt <= runOe_n[0] ? 0 : lowCnt + 1;
        end
    end
    a_sync_width: assert property ($fell(syncOe_n) |-> !syncOe_n [*5] ##1 syncOe_n)
        else $error("sync pulse width wrong");
    a_pad_driver: assert property ($fell(syncOe_n) |-> ##[0:3] padStatusWord[10])
        else $error("pad status does not show driver");
    a_fault_stop: assert property (faultDetected[0] |-> ##[1:2] !switching[0])
        else $error("fault did not stop switching");
    a_vin_stop: assert property (vinBelowOff |-> ##[1:2] switching == 2'h0)
        else $error("low input did not stop switching");
    a_cfg_refused: assert property (cfgWrite && switching != 2'h0 |-> ##[1:2] cfgRefused)
        else $error("config write while on not refused");
    a_cfg_held: assert property (cfgWrite && switching != 2'h0 |=> $stable(pwmPhaseConfig) [*2])
        else $error("config changed while on");
    a_comp_fields: assert property (compResistor == loop_compensation_setting[4:0]
        && errorAmpGm == loop_compensation_setting[7:5])
        else $error("compensation fields wrong");
    a_comp_write: assert property (compWriteEn |=> loop_compensation_setting == $past(compWrite))
        else $error("compensation write lost");
    a_dcm_sink: assert property (!continuousMode[0] |-> !sinkEnable[0])
        else $error("sinking in discontinuous mode");
    a_start_dcm: assert property ($rose(switching[0]) |-> !continuousMode[0])
        else $error("start not discontinuous");
    a_restart_hold: assert property ($rose(runOe_n[0]) |-> lowCnt >= RESTART_EXTRA)
        else $error("run hold too short");
endmodule // channel_shutdown_retry_sync_control_assertions
bind channel_shutdown_retry_sync_control channel_shutdown_retry_sync_control_assertions #(
    .CHANNELS(CHANNELS), .RESTART_EXTRA(RESTART_EXTRA)) chk (.*);
`default_nettype wire

/* tb/sync_peer.sv */
`timescale 1ns/1ps
`default_nettype none
module sync_peer (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic peerMaster,
    input wire logic hostRunLow,
    input wire logic syncOe_n,
    input wire logic [1:0] runOe_n,
    output logic syncIn,
    output logic [1:0] runIn,
    output logic shareClkIn
);
    logic [5:0] cnt;
    // Period 37 drifts against the device's 40
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 6'h0;
        end else begin
            cnt <= (cnt == 6'h24) ? 6'h0 : cnt + 6'h1;
        end
    end
    // Pulled-up open-drain lines: low while any party pulls
    assign syncIn = syncOe_n & !(peerMaster && cnt < 6'h5);
    assign runIn = runOe_n & ~{2{hostRunLow}};
    assign shareClkIn = cnt[2];
endmodule // sync_peer
`default_nettype wire

/* tb/channel_shutdown_retry_sync_control_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module channel_shutdown_retry_sync_control_tb_top;
    logic clock = 1'h0, rst_n = 1'h0, vinBelowOff = 1'h0, syncMasterCfg = 1'h0, cfgWrite = 1'h0;
    logic compWriteEn = 1'h0, peerMaster = 1'h0, hostRunLow = 1'h0;
    logic [1:0] opOn = 2'h0, faultDetected = 2'h0, faultPinLow = 2'h0, inhibitResponse = 2'h0, latchOff = 2'h0;
    logic [1:0] vinOverLimit = 2'h0, belowEighth = 2'h3, belowVoffThreshold = 2'h3, rampDone = 2'h3;
    logic [1:0] forcedContinuous = 2'h3;
    logic [7:0] globalConfig = 8'h0, pwmConfigIn = 8'h0, compWrite = 8'h0;
    logic [7:0] channelConfig [2] = '{8'h0, 8'h0};
    logic [23:0] turnOffWait [2] = '{24'hA, 24'hA}, rampDownTime [2] = '{24'hA, 24'hA};
    logic [31:0] retryWait [2] = '{32'h1E, 32'h1E}, restartHold [2] = '{32'h0, 32'h0};
    logic [31:0] turnOffMaxWarnLimit [2] = '{32'hFF, 32'hFF};
    logic [15:0] periodCycles = 16'h28;
    logic [15:0] phaseCycles [2] = '{16'h0, 16'h8};
    wire logic [1:0] runOut, runOe_n, runIn, switching, sinkEnable, continuousMode, topSwitchSet, turnOffMaxWarn;
    wire logic [1:0] inputSenseGain;
    wire logic syncOut, syncOe_n, syncIn, shareClkIn, cfgRefused;
    wire logic [4:0] compResistor;
    wire logic [2:0] errorAmpGm;
    wire logic [7:0] loop_compensation_setting, pwmPhaseConfig;
    wire logic [15:0] padStatusWord;
    int n_checks = 0, miscompares = 0, cycles = 0, i;
    channel_shutdown_retry_sync_control #(.VOFF_SETTLE(20), .RESTART_EXTRA(20)) dut (.*);
    sync_peer peer (.clock(clock), .rst_n(rst_n), .peerMaster(peerMaster), .hostRunLow(hostRunLow),
        .syncOe_n(syncOe_n), .runOe_n(runOe_n), .syncIn(syncIn), .runIn(runIn), .shareClkIn(shareClkIn));
    always #50 clock = ~clock;
    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Bounded wait, sampled mid-cycle
    task wait_sw(input logic [1:0] exp);
        for (i = 0; i < 400 && switching !== exp; i++) @(negedge clock);
        chk(switching, exp);
    endtask
    task pulse_fault;
        @(posedge clock) faultDetected <= 2'h1;
        @(posedge clock) faultDetected <= 2'h0;
    endtask
    task test_done;
        $display("Checks: %0d, mismatches: %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Hang guard
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            miscompares++;
            test_done;
        end
    end
    initial begin
        repeat (10) @(posedge clock);
        rst_n <= 1'h1;
        @(negedge clock);
        chk(loop_compensation_setting, shutdown_pkg::COMP_RESET);
        chk(pwmPhaseConfig, shutdown_pkg::PWM_CONFIG_RESET);
        @(posedge clock) {compWrite, compWriteEn, pwmConfigIn, cfgWrite} <= {8'hA5, 1'h1, 8'h40, 1'h1};
        @(posedge clock) {compWriteEn, cfgWrite} <= 2'h0;
        repeat (3) @(negedge clock);
        chk(compResistor, 5'h05);
        chk(errorAmpGm, 3'h5);
        chk(pwmPhaseConfig, 8'h40);
        chk(inputSenseGain, 2'h2);
        $display("Test registers done");
        @(posedge clock) opOn <= 2'h1;
        wait_sw(2'h1);
        repeat (20) @(negedge clock);
        chk(continuousMode, 2'h1);
        @(posedge clock) {pwmConfigIn, cfgWrite} <= {8'h20, 1'h1};
        @(posedge clock) cfgWrite <= 1'h0;
        @(negedge clock);
        chk(cfgRefused, 1'h1);
        chk(pwmPhaseConfig, 8'h40);
        @(posedge clock) hostRunLow <= 1'h1;
        repeat (3) @(posedge clock);
        hostRunLow <= 1'h0;
        for (i = 0; i < 100 && sinkEnable[0] !== 1'h1; i++) @(negedge clock);
        chk(sinkEnable[0], 1'h1);
        wait_sw(2'h0);
        chk(runOe_n[0], 1'h0);
        wait_sw(2'h1);
        $display("Test shutdown done");
        pulse_fault;
        repeat (3) @(negedge clock);
        chk(switching, 2'h0);
        repeat (20) @(negedge clock);
        chk(switching, 2'h0);
        wait_sw(2'h1);
        @(posedge clock) latchOff <= 2'h1;
        pulse_fault;
        repeat (100) @(negedge clock);
        chk(switching, 2'h0);
        @(posedge clock) opOn <= 2'h0;
        @(posedge clock) opOn <= 2'h1;
        wait_sw(2'h1);
        @(posedge clock) vinBelowOff <= 1'h1;
        @(posedge clock) vinBelowOff <= 1'h0;
        repeat (3) @(negedge clock);
        chk(switching, 2'h0);
        $display("Test faults done");
        @(posedge clock) syncMasterCfg <= 1'h1;
        for (i = 0; i < 200 && syncOe_n !== 1'h0; i++) @(negedge clock);
        chk(syncOe_n, 1'h0);
        repeat (3) @(negedge clock);
        chk(padStatusWord[10], 1'h1);
        @(posedge clock) peerMaster <= 1'h1;
        repeat (300) @(negedge clock);
        chk(padStatusWord[10], 1'h0);
        $display("Test sync done");
        test_done;
    end
endmodule // channel_shutdown_retry_sync_control_tb_top
`default_nettype wire
